// ---- rtl/arpt_pkg.sv ----
// Summary of operation
// - Two-bit field selects off, slow tick, CPU clock
// - Counter starts at zero, counts each tick
// - Past FFFh reload, set overflow; read clears
// - Overflow flag holds two counter clock periods
// - Overflow request when flag and enable set
// - Pulse frequency is tick over 4096 minus reload
// - Overflow reloads, copies duty, drives output high
// - Pulse mode: output low at duty match
// - Polarity bit inverts the pulse output
// - Output enable selects pulse mode and pin drive
// - High duty write suspends compare until low
// - Compare mode duty takes effect at once
// - Match sets compare flag; enable gates request
// - No compare while duty value is zero
// - Overflow copies written duty into shadow
// - Slow divides by 32; halt stops timer, active-halt runs only on slow tick with overflow irq
// - Wake rules for wait, halt, active-halt
// - Compare enable masks request; reset clears it
// - Compare flag cleared by reading its register
// - Polarity clear drives output uninverted
package arpt_pkg;
	localparam logic [7:0] ARPT_OFS_CSR = 8'h00;
	localparam logic [7:0] ARPT_OFS_CNTH = 8'h04;
	localparam logic [7:0] ARPT_OFS_CNTL = 8'h08;
	localparam logic [7:0] ARPT_OFS_RLDH = 8'h0c;
	localparam logic [7:0] ARPT_OFS_RLDL = 8'h10;
	localparam logic [7:0] ARPT_OFS_OUTCR = 8'h14;
	localparam logic [7:0] ARPT_OFS_OUTCSR = 8'h18;
	localparam logic [7:0] ARPT_OFS_DUTH = 8'h1c;
	localparam logic [7:0] ARPT_OFS_DUTL = 8'h20;
	localparam logic [7:0] ARPT_OFS_PWR = 8'h24;
	// Control/status field positions
	localparam int ARPT_CSR_CK_LO = 3;
	localparam int ARPT_CSR_OVF = 2;
	localparam int ARPT_CSR_OVERFLOW_IRQ_ENABLE = 1;
	localparam int ARPT_CSR_COMPARE_IRQ_ENABLE = 0;
	localparam int ARPT_OCSR_POL = 1;
	localparam int ARPT_OCSR_CMPF = 0;
	localparam int ARPT_OCR_OE = 0;
	// Power mode register: bit0 slow, bits 2:1 mode
	localparam int ARPT_PWR_SLOW = 0;
	localparam logic [1:0] ARPT_PM_RUN = 2'h0;
	localparam logic [1:0] ARPT_PM_WAIT = 2'h1;
	localparam logic [1:0] ARPT_PM_AHALT = 2'h2;
	localparam logic [1:0] ARPT_PM_HALT = 2'h3;
	// Clock selection codes
	localparam logic [1:0] ARPT_CK_OFF = 2'h0;
	localparam logic [1:0] ARPT_CK_SLOW = 2'h1;
	localparam logic [1:0] ARPT_CK_CPU = 2'h2;
	localparam logic [11:0] ARPT_CNT_MAX = 12'hfff;
	localparam logic [11:0] ARPT_ZERO12 = 12'h000;
	localparam int ARPT_SLOW_DIV = 32;
	localparam logic [1:0] ARPT_RESP_OKAY = 2'h0;
	localparam logic [1:0] ARPT_RESP_SLVERR = 2'h2;
endpackage : arpt_pkg

// ---- rtl/arpt_tick_div.sv ----
`timescale 1ns/1ps
// Divides an enable stream by DIV, producing one-cycle pulses
module arpt_tick_div #(
	parameter int DIV = 32
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic tickIn,
	output logic tickOut
);
	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	// Refused at elaboration: with a zero divider LAST wraps to 1, so it would pulse every second tick
	if (DIV < 1)
	begin : g_div_check
		$error("arpt_tick_div: DIV must be at least 1");
	end
	logic [CW-1:0] count; // Input ticks seen this period
	// Count input ticks, pulse on the last one of each period
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			count <= '0;
			tickOut <= 1'b0;
		end
		else
		begin
			tickOut <= 1'b0;
			if (tickIn)
			begin
				if (count == LAST)
				begin
					count <= '0;
					tickOut <= 1'b1;
				end
				else
					count <= count + CW'(1);
			end
		end
	end
endmodule : arpt_tick_div

// ---- rtl/arpt_timer.sv ----
`timescale 1ns/1ps
// Autoreload pulse timer with AXI4-Lite register access
module arpt_timer #(
	parameter int CNT_W = 12
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic slowTickIn, // Low-rate tick, from a pin domain
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pulseOutput,
	output logic pulseOutputEn,
	output logic overflowIrq,
	output logic compareIrq,
	output logic wakeRequest
);
	import arpt_pkg::*;
	// Byte-wide register halves and the FFFh wrap assume exactly 12 bits
	if (CNT_W != 12)
	begin : g_cnt_w_check
		$error("arpt_timer: only a 12-bit counter is supported");
	end

	// Block state, apart from the tick synchroniser and divider
	typedef struct packed {
		logic [1:0] clkSel;
		logic overflowFlag;
		logic ovfHold; // Flag must survive the next counter tick
		logic overflowIrqEnable;
		logic compareIrqEnable;
		logic compareMatchFlag;
		logic outputPolarity;
		logic pulseOutputEnable;
		logic [11:0] countValue;
		logic [11:0] reloadValue;
		logic [11:0] dutyValue;
		logic [11:0] dutyShadow;
		logic compareLocked; // High byte written, low still pending
		logic slowMode;
		logic [1:0] powerMode;
		logic pulseLevel;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic ovfIrq;
		logic cmpIrq;
		logic wake;
		logic pinOut;
		logic pinEn;
	} arpt_state_s;

	arpt_state_s st;
	arpt_state_s next_st;

	// Two-flop synchroniser for the external slow tick
	// Only the second flop feeds logic; the third just delays it for edges
	logic slowSync1;
	logic slowSync2;
	logic slowSync3;
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			slowSync1 <= 1'b0;
			slowSync2 <= 1'b0;
			slowSync3 <= 1'b0;
		end
		else
		begin
			slowSync1 <= slowTickIn;
			slowSync2 <= slowSync1;
			slowSync3 <= slowSync2;
		end
	end
	// Rising edge of the synchronised tick, one cycle wide
	// All three flops reset low, matching the idle pin, so no false edge
	logic slowEdge;
	assign slowEdge = slowSync2 & ~slowSync3;

	// Raw counter clock ahead of slow-mode division
	// Reserved select code falls into the default and stops the counter
	logic rawTick;
	logic divTick;
	always_comb
	begin
		unique case (st.clkSel)
			ARPT_CK_SLOW: rawTick = slowEdge;
			ARPT_CK_CPU: rawTick = 1'b1;
			default: rawTick = 1'b0;
		endcase
	end

	// Slow mode divides the counter input by 32
	arpt_tick_div #(
		.DIV(ARPT_SLOW_DIV)
	) u_slow_div (
		.clk_sys(clk_sys),
		.srst(srst),
		.tickIn(rawTick),
		.tickOut(divTick)
	);

	// Halt stops; active-halt runs only on slow tick with overflow irq
	// Wait mode is not listed, so it leaves the counter running
	logic runAllowed;
	logic cntTick;
	always_comb
	begin
		unique case (st.powerMode)
			ARPT_PM_HALT: runAllowed = 1'b0;
			ARPT_PM_AHALT: runAllowed = (st.clkSel == ARPT_CK_SLOW) && st.overflowIrqEnable;
			default: runAllowed = 1'b1;
		endcase
		cntTick = runAllowed && (st.slowMode ? divTick : rawTick);
	end

	// Read value mux, shared by the read path
	// Unused upper bits always read back as zero
	function automatic logic [31:0] readMux(input arpt_state_s s, input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		unique case (a)
			ARPT_OFS_CSR: v[4:0] = {s.clkSel, s.overflowFlag, s.overflowIrqEnable,
				s.compareIrqEnable};
			ARPT_OFS_CNTH: v[3:0] = s.countValue[11:8];
			ARPT_OFS_CNTL: v[7:0] = s.countValue[7:0];
			ARPT_OFS_RLDH: v[3:0] = s.reloadValue[11:8];
			ARPT_OFS_RLDL: v[7:0] = s.reloadValue[7:0];
			ARPT_OFS_OUTCR: v[ARPT_OCR_OE] = s.pulseOutputEnable;
			ARPT_OFS_OUTCSR: v[1:0] = {s.outputPolarity, s.compareMatchFlag};
			ARPT_OFS_DUTH: v[3:0] = s.dutyValue[11:8];
			ARPT_OFS_DUTL: v[7:0] = s.dutyValue[7:0];
			ARPT_OFS_PWR: v[2:0] = {s.powerMode, s.slowMode};
			default: v = 32'h0;
		endcase
		return v;
	endfunction : readMux

	// Word-aligned offsets up to the power register answer OKAY
	function automatic logic isMapped(input logic [7:0] a);
		return (a <= ARPT_OFS_PWR) && (a[1:0] == 2'b00);
	endfunction : isMapped

	// Next-state logic for bus, counter and output
	always_comb
	begin
		logic doWrite;
		logic doRead;
		logic [7:0] wb;
		logic [11:0] cmpRef;
		logic cmpHit;
		logic ovfEvt;
		logic csrRead;
		logic ocsrRead;
		doWrite = 1'b0;
		doRead = 1'b0;
		wb = 8'h0;
		cmpRef = 12'h0;
		cmpHit = 1'b0;
		ovfEvt = 1'b0;
		csrRead = 1'b0;
		ocsrRead = 1'b0;
		next_st = st;

		// Capture write address and data in either order
		// Ready is low while a half is held, so a second beat simply waits
		if (s_axi_awvalid && !st.awHeld)
		begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.wHeld)
		begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata;
			next_st.wStrb = s_axi_wstrb;
		end
		// Response stands until the master takes it
		if (st.bValid && s_axi_bready)
			next_st.bValid = 1'b0;
		if (st.awHeld && st.wHeld && !st.bValid)
		begin
			doWrite = st.wStrb[0];
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bValid = 1'b1;
			next_st.bResp = isMapped(st.awAddr) ? ARPT_RESP_OKAY : ARPT_RESP_SLVERR;
		end
		// Registers are byte wide, so only lane 0 carries data
		wb = st.wData[7:0];

		// Read path: one-cycle latency, side effects on the taken edge
		// A new read waits until the previous answer was taken
		if (st.rValid && s_axi_rready)
			next_st.rValid = 1'b0;
		if (s_axi_arvalid && !st.rValid)
		begin
			doRead = 1'b1;
			next_st.rValid = 1'b1;
			next_st.rData = readMux(st, s_axi_araddr);
			next_st.rResp = isMapped(s_axi_araddr) ? ARPT_RESP_OKAY : ARPT_RESP_SLVERR;
		end
		csrRead = doRead && (s_axi_araddr == ARPT_OFS_CSR);
		ocsrRead = doRead && (s_axi_araddr == ARPT_OFS_OUTCSR);

		// Register writes; flags are not writable
		// Counter and unknown offsets fall to the default and change nothing
		if (doWrite)
		begin
			unique case (st.awAddr)
				ARPT_OFS_CSR:
				begin
					next_st.clkSel = wb[ARPT_CSR_CK_LO +: 2];
					next_st.overflowIrqEnable = wb[ARPT_CSR_OVERFLOW_IRQ_ENABLE];
					next_st.compareIrqEnable = wb[ARPT_CSR_COMPARE_IRQ_ENABLE];
				end
				ARPT_OFS_RLDH: next_st.reloadValue[11:8] = wb[3:0];
				ARPT_OFS_RLDL: next_st.reloadValue[7:0] = wb;
				ARPT_OFS_OUTCR: next_st.pulseOutputEnable = wb[ARPT_OCR_OE];
				ARPT_OFS_OUTCSR: next_st.outputPolarity = wb[ARPT_OCSR_POL];
				ARPT_OFS_DUTH:
				begin
					next_st.dutyValue[11:8] = wb[3:0];
					next_st.compareLocked = 1'b1;
				end
				ARPT_OFS_DUTL:
				begin
					next_st.dutyValue[7:0] = wb;
					next_st.compareLocked = 1'b0;
				end
				ARPT_OFS_PWR:
				begin
					next_st.slowMode = wb[ARPT_PWR_SLOW];
					next_st.powerMode = wb[2:1];
				end
				default: ;
			endcase
		end

		// Read-to-clear; a set in the same cycle still wins below
		if (csrRead)
			next_st.overflowFlag = 1'b0;
		if (ocsrRead)
			next_st.compareMatchFlag = 1'b0;

		// Counter and compare, one step per counter tick
		if (cntTick)
		begin
			// Flag stays high for two full counter periods
			// Hold absorbs the first tick after overflow; the next tick drops the flag
			if (st.ovfHold)
				next_st.ovfHold = 1'b0;
			else
				next_st.overflowFlag = 1'b0;
			if (st.countValue == ARPT_CNT_MAX)
			begin
				ovfEvt = 1'b1;
				next_st.countValue = st.reloadValue;
				next_st.overflowFlag = 1'b1;
				next_st.ovfHold = 1'b1;
				next_st.dutyShadow = st.dutyValue;
				next_st.pulseLevel = 1'b1;
			end
			else
				next_st.countValue = st.countValue + 12'h001;
			// Pulse mode uses the shadow, compare mode the written value
			// Zero duty or a half-written duty keeps compare from firing
			cmpRef = st.pulseOutputEnable ? st.dutyShadow : st.dutyValue;
			cmpHit = !st.compareLocked && (cmpRef != ARPT_ZERO12)
				&& (st.countValue == cmpRef);
			if (cmpHit)
			begin
				next_st.compareMatchFlag = 1'b1;
				if (st.pulseOutputEnable && !ovfEvt)
					next_st.pulseLevel = 1'b0;
			end
		end

		// Interrupt requests and wake
		// Separate request lines keep overflow and compare on their own vectors
		next_st.ovfIrq = next_st.overflowFlag && next_st.overflowIrqEnable;
		next_st.cmpIrq = next_st.compareMatchFlag && next_st.compareIrqEnable;
		unique case (next_st.powerMode)
			ARPT_PM_WAIT: next_st.wake = next_st.ovfIrq || next_st.cmpIrq;
			ARPT_PM_AHALT: next_st.wake = next_st.ovfIrq
				&& (next_st.clkSel == ARPT_CK_SLOW);
			ARPT_PM_HALT: next_st.wake = 1'b0;
			default: next_st.wake = 1'b0;
		endcase

		// Pin drive: polarity inverts, disabled pin is released
		// Forcing the pin low while disabled keeps a stale level from leaking out
		next_st.pinOut = next_st.pulseOutputEnable
			&& (next_st.pulseLevel ^ next_st.outputPolarity);
		next_st.pinEn = next_st.pulseOutputEnable;
	end

	// Register the whole state
	// Synchronous reset clears every control bit, flag and the counter
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	// Outputs straight from state flops
	// Ready outputs are only inverted hold and read-valid flops, so they stay glitch free
	assign s_axi_awready = ~st.awHeld;
	assign s_axi_wready = ~st.wHeld;
	assign s_axi_bvalid = st.bValid;
	assign s_axi_bresp = st.bResp;
	assign s_axi_arready = ~st.rValid;
	assign s_axi_rvalid = st.rValid;
	assign s_axi_rdata = st.rData;
	assign s_axi_rresp = st.rResp;
	assign pulseOutput = st.pinOut;
	assign pulseOutputEn = st.pinEn;
	assign overflowIrq = st.ovfIrq;
	assign compareIrq = st.cmpIrq;
	assign wakeRequest = st.wake;
endmodule : arpt_timer

// ---- tb/arpt_timer_props.sv ----
`timescale 1ns/1ps
// Port relations of the timer: bus handshakes, reset state, pin enable
module arpt_timer_props #(
	parameter int CNT_W = 12
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pulseOutput,
	input wire logic pulseOutputEn,
	input wire logic overflowIrq,
	input wire logic compareIrq
);
	import arpt_pkg::*;
	// One clock domain, so one default clock and reset
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// Reset must be checked while it is asserted, so it is never disabled
	property p_rst;
		disable iff (1'b0) srst |=> !s_axi_bvalid && !s_axi_rvalid && s_axi_arready
			&& !pulseOutputEn && !overflowIrq && !compareIrq;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	// Pin stays low once the enable has been off for two samples
	property p_oe_low;
		!pulseOutputEn && !$past(pulseOutputEn) |-> !pulseOutput;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("pin high while disabled");
	// Enable only moves around a write response
	property p_oe_wr;
		$changed(pulseOutputEn) |-> (s_axi_bvalid || $past(s_axi_bvalid)) or ##1 s_axi_bvalid;
	endproperty
	a_oe_wr: assert property (p_oe_wr) else $error("enable moved without a write");
	// Response only after both halves were taken
	property p_b_first;
		$rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready);
	endproperty
	a_b_first: assert property (p_b_first) else $error("early write response");
	// Write response stands until accepted
	property p_b_stand;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_stand: assert property (p_b_stand) else $error("write response dropped");
	// Read answer one cycle after the address is taken
	property p_r_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("read answer late");
	// Read data stands until accepted
	property p_r_stand;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_stand: assert property (p_r_stand) else $error("read data dropped");
	// Refused reads return zero, so nonzero data must be an okay read
	property p_resp;
		s_axi_rvalid && s_axi_rdata != 32'h0 |-> s_axi_rresp == ARPT_RESP_OKAY;
	endproperty
	a_resp: assert property (p_resp) else $error("data on refused read");
endmodule : arpt_timer_props

bind arpt_timer arpt_timer_props #(.CNT_W(CNT_W)) u_arpt_timer_props (.*);

// ---- tb/arpt_timer_tb_top.sv ----
`timescale 1ns/1ps
// Register-bus driven checks of the autoreload pulse timer
module arpt_timer_tb_top;
	import arpt_pkg::*;
	logic clk_sys = 0, srst = 1, slowTickIn = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd0, rd1;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, hit;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic pulseOutput, pulseOutputEn, overflowIrq, compareIrq, wakeRequest;
	int errTotal = 0, comparisons = 0, hi, per;
	// Row: address, value written, value read back, response
	typedef struct packed {logic [7:0] a; logic [31:0] w, r; logic [1:0] b;} arpt_row_s;
	arpt_row_s rows [7] = '{'{ARPT_OFS_RLDH, 32'hf, 32'hf, 2'h0},
		'{ARPT_OFS_RLDL, 32'ha0, 32'ha0, 2'h0}, '{ARPT_OFS_DUTH, 32'hf, 32'hf, 2'h0},
		'{ARPT_OFS_DUTL, 32'hd2, 32'hd2, 2'h0}, '{ARPT_OFS_OUTCSR, 32'h3, 32'h2, 2'h0},
		'{ARPT_OFS_CSR, 32'h1f, 32'h1b, 2'h0}, '{8'h40, 32'h55, 32'h0, ARPT_RESP_SLVERR}};

	arpt_timer u_arpt_timer (.*);

	// Free-running 50 ns clock
	initial
	begin
		forever #25 clk_sys = ~clk_sys;
	end
	// Slow tick keeps running so the slow select always has edges
	always
	begin
		repeat (5) @(posedge clk_sys);
		slowTickIn <= ~slowTickIn;
	end
	// Compare task: counts every call, reports mismatches at once
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			errTotal++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	task rst();
		srst <= 1'b1;
		cyc(16);
		srst <= 1'b0;
		cyc(1);
	endtask : rst
	// Write: both halves offered together, bready late to see bvalid stand
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ga, gw;
		ga = 0;
		gw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ga && gw))
		begin
			@(posedge clk_sys);
			if (!ga && s_axi_awready)
			begin
				ga = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!gw && s_axi_wready)
			begin
				gw = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		cyc(2);
		s_axi_bready <= 1'b1;
		do
			@(posedge clk_sys);
		while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// Read: rready raised one cycle late for the same reason
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
			@(posedge clk_sys);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		cyc(1);
		s_axi_rready <= 1'b1;
		do
			@(posedge clk_sys);
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	// Bounded wait for compare (0), overflow (1), pin (2) or wake (3)
	task wait_for(input int sel, input int lim, output logic h);
		h = 1'b0;
		for (int k = 0; k < lim && !h; k++)
		begin
			@(posedge clk_sys);
			h = sel == 0 ? compareIrq : sel == 1 ? overflowIrq : sel == 2 ? pulseOutput : wakeRequest;
		end
	endtask : wait_for
	// High time and period of one whole pin cycle, in clocks
	task meas(output int h, output int p);
		h = 0;
		while (pulseOutput !== 1'b0) @(posedge clk_sys);
		while (pulseOutput !== 1'b1) @(posedge clk_sys);
		while (pulseOutput === 1'b1)
		begin
			h++;
			@(posedge clk_sys);
		end
		p = h;
		while (pulseOutput !== 1'b1)
		begin
			p++;
			@(posedge clk_sys);
		end
	endtask : meas
	task print_verdict();
		$display("Comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	// Watchdog: the whole run needs well under this
	initial
	begin
		cyc(80000);
		errTotal++;
		print_verdict();
	end
	initial
	begin
		rst();
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].w, rsp);
			chk("bresp", rsp, rows[i].b);
			rd(rows[i].a, rd0, rsp);
			chk("rdata", rd0, rows[i].r);
			chk("rresp", rsp, rows[i].b);
		end
		rst();
		for (int a = 0; a <= 9; a++)
		begin
			rd(8'(a * 4), rd0, rsp);
			chk("reset value", rd0, 0);
		end
		// Clock codes, then wait and halt with the CPU clock
		// Steps 6 and 7: active-halt stops the CPU clock, not slow tick with overflow irq
		for (int i = 0; i < 8; i++)
		begin
			wr(ARPT_OFS_PWR, i == 4 ? 32'h2 : i == 5 ? 32'h6 : i > 5 ? 32'h4 : 32'h0, rsp);
			wr(ARPT_OFS_CSR, i == 7 ? 32'h0a : (i < 4 ? i : 2) << 3, rsp);
			rd(ARPT_OFS_CNTL, rd0, rsp);
			cyc(20);
			rd(ARPT_OFS_CNTL, rd1, rsp);
			chk("count moves", rd0 != rd1, i == 1 || i == 2 || i == 4 || i == 7);
		end
		// Slow mode on the CPU clock: 96 cycles between samples give 3 steps
		wr(ARPT_OFS_PWR, 32'h1, rsp);
		wr(ARPT_OFS_CSR, 32'h10, rsp);
		rd(ARPT_OFS_CNTL, rd0, rsp);
		cyc(93);
		rd(ARPT_OFS_CNTL, rd1, rsp);
		chk("slow divide", 8'(rd1 - rd0), 3);
		rst();
		wr(ARPT_OFS_CSR, 32'h11, rsp);
		wait_for(0, 4200, hit);
		chk("cmp at zero", hit, 0);
		wr(ARPT_OFS_DUTH, 32'h0, rsp);
		wr(ARPT_OFS_DUTL, 32'h10, rsp);
		wait_for(0, 4200, hit);
		chk("cmp irq", hit, 1);
		rd(ARPT_OFS_OUTCSR, rd0, rsp);
		chk("cmp flag", rd0, 1);
		cyc(2);
		chk("cmp irq cleared", compareIrq, 0);
		// High byte alone locks the compare
		wr(ARPT_OFS_DUTH, 32'h0, rsp);
		wait_for(0, 4200, hit);
		chk("cmp locked", hit, 0);
		wr(ARPT_OFS_DUTL, 32'h20, rsp);
		wait_for(0, 4200, hit);
		chk("cmp resumed", hit, 1);
		wr(ARPT_OFS_CSR, 32'h10, rsp);
		rd(ARPT_OFS_OUTCSR, rd0, rsp);
		wait_for(0, 4200, hit);
		chk("cmp masked", hit, 0);
		rd(ARPT_OFS_OUTCSR, rd0, rsp);
		chk("flag while masked", rd0, 1);
		wr(ARPT_OFS_CSR, 32'h12, rsp);
		wait_for(1, 4200, hit);
		chk("ovf irq", hit, 1);
		wr(ARPT_OFS_CSR, 32'h10, rsp);
		wait_for(1, 4200, hit);
		chk("ovf masked", hit, 0);
		// Wait mode wakes on overflow; halt never wakes
		wr(ARPT_OFS_PWR, 32'h2, rsp);
		wr(ARPT_OFS_CSR, 32'h12, rsp);
		wait_for(3, 4200, hit);
		chk("wake in wait", hit, 1);
		wr(ARPT_OFS_PWR, 32'h6, rsp);
		wait_for(3, 100, hit);
		chk("no wake in halt", hit, 0);
		// Reload 4000, duty 4050: period 96, high 51
		rst();
		wr(ARPT_OFS_RLDH, 32'hf, rsp);
		wr(ARPT_OFS_RLDL, 32'ha0, rsp);
		wr(ARPT_OFS_DUTH, 32'hf, rsp);
		wr(ARPT_OFS_DUTL, 32'hd2, rsp);
		wr(ARPT_OFS_OUTCR, 32'h1, rsp);
		wr(ARPT_OFS_CSR, 32'h10, rsp);
		chk("pin enable", pulseOutputEn, 1);
		meas(hi, per);
		chk("period", per, 96);
		chk("high time", hi, 51);
		wr(ARPT_OFS_OUTCSR, 32'h2, rsp);
		meas(hi, per);
		chk("inverted high", hi, 45);
		wr(ARPT_OFS_OUTCR, 32'h0, rsp);
		cyc(3);
		chk("pin off", {pulseOutputEn, pulseOutput}, 0);
		print_verdict();
	end
endmodule : arpt_timer_tb_top
